// [verilog/adsp_host.sv]
/*
 * Host controller driving the accelerometer serial port over I2C or
 * four-wire SPI. Assumes open-drain SCL/SDA resolved outside from the
 * enables, and pins asynchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module adsp_host
   import adsp_pkg::*;
#(
   parameter int CONV_CYCLES = adsp_pkg::CONV_WAIT_CYCLES,
   parameter int QTR_CYCLES  = adsp_pkg::I2C_QTR_CYCLES,
   parameter int HALF_CYCLES = adsp_pkg::SPI_HALF_CYCLES,
   parameter bit INIT_SPI    = 1'b0
) (
   input  wire logic                  mclk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  addr_strap_i,
   input  wire logic                  cmd_valid_i,
   input  wire adsp_pkg::adsp_cmd_type cmd_i,
   output logic                       cmd_ready_o,
   output logic [7:0]                 rd_data_o,
   output logic                       rd_valid_o,
   output logic                       done_o,
   output logic                       nack_o,
   input  wire logic                  scl_i,
   output logic                       scl_o,
   output logic                       scl_oe_o,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe_o,
   output logic                       sclk_o,
   output logic                       mosi_o,
   output logic                       chip_select_n_o,
   input  wire logic                  miso_i
);
   import adsp_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic       scl_s, sda_s, miso_s;

   always_ff @(posedge mclk_i) begin
      sync1_reg <= {scl_i, sda_i, miso_i};
      sync2_reg <= sync1_reg;
   end
   assign {scl_s, sda_s, miso_s} = sync2_reg;

   // ------------------------------------------------------------
   // controller
   // ------------------------------------------------------------
   adsp_ctl_type ctl_reg, ctl_next;
   logic         tick, last_rd, rx;
   logic [8:0]   spi_bytes;

   function automatic logic [7:0] reload(input logic spi);
      reload = spi ? 8'(HALF_CYCLES - 1) : 8'(QTR_CYCLES - 1);
   endfunction

   assign tick    = (ctl_reg.div == 8'h00);
   assign rx      = (ctl_reg.seg == SEG_RDATA);
   assign last_rd = ({1'b0, ctl_reg.byte_cnt} + 9'h001)
                    >= {1'b0, ctl_reg.cmd.count};
   // a zero count still reads one byte, as the I2C path does
   assign spi_bytes = (ctl_reg.cmd.op == OP_WRITE) ? SPI_WR_BYTES
                      : (ctl_reg.cmd.count == 8'h00) ? SPI_WR_BYTES
                      : {1'b0, ctl_reg.cmd.count} + 9'h001;

   always_comb begin
      adsp_cmd_type c;
      c            = cmd_i;
      ctl_next     = ctl_reg;
      ctl_next.rd_valid = 1'b0;
      ctl_next.done     = 1'b0;
      ctl_next.div = tick ? reload(ctl_reg.cmd.proto_spi)
                          : ctl_reg.div - 8'h01;
      case (ctl_reg.st)
         ST_IDLE: begin
            if (ctl_reg.init_pend || cmd_valid_i) begin
               if (ctl_reg.init_pend) begin
                  // power-up mode byte before any user request
                  c = '{INIT_SPI, OP_WRITE, CFG_B_INDEX, CFG_B_INIT, 8'h01};
               end
               ctl_next.init_pend = 1'b0;
               ctl_next.cmd       = c;
               ctl_next.err       = 1'b0;
               ctl_next.byte_cnt  = 8'h00;
               ctl_next.q         = 2'h0;
               ctl_next.div       = reload(c.proto_spi);
               if (c.proto_spi) begin
                  ctl_next.st      = ST_SPI_SEL;
                  ctl_next.cs_n    = 1'b0;
                  ctl_next.sh      = {c.op != OP_WRITE, c.index[6:0]};
                  ctl_next.bit_cnt = {1'b0, SPI_BIT_LAST};
               end else begin
                  ctl_next.st  = ST_I2C_START;
                  ctl_next.seg = SEG_ADDR_W;
               end
            end
         end
         ST_I2C_START: if (tick) begin
            case (ctl_reg.q)
               2'h0: begin
                  ctl_next.sda_oe = 1'b0;
                  ctl_next.scl_oe = 1'b0;
                  ctl_next.q      = 2'h1;
               end
               2'h1: if (scl_s) ctl_next.q = 2'h2;
               2'h2: begin
                  ctl_next.sda_oe = 1'b1;
                  ctl_next.q      = 2'h3;
               end
               default: begin
                  ctl_next.scl_oe  = 1'b1;
                  ctl_next.q       = 2'h0;
                  ctl_next.bit_cnt = I2C_SLOT_LAST;
                  ctl_next.sh      = {TARGET_ADDR_HI, addr_strap_i,
                                      ctl_reg.seg == SEG_ADDR_R};
                  ctl_next.st      = ST_I2C_BIT;
               end
            endcase
         end
         ST_I2C_BIT: if (tick) begin
            case (ctl_reg.q)
               2'h0: begin
                  if (ctl_reg.bit_cnt != 4'h0) begin
                     ctl_next.sda_oe = rx ? 1'b0 : !ctl_reg.sh[7];
                  end else begin
                     ctl_next.sda_oe = rx && !last_rd;
                  end
                  ctl_next.q = 2'h1;
               end
               2'h1: begin
                  ctl_next.scl_oe = 1'b0;
                  ctl_next.q      = 2'h2;
               end
               2'h2: if (scl_s) begin
                  // a stretched SCL simply holds us here
                  if (ctl_reg.bit_cnt != 4'h0) begin
                     ctl_next.sh = {ctl_reg.sh[6:0], rx ? sda_s : 1'b0};
                  end else begin
                     ctl_next.nak = sda_s;
                  end
                  ctl_next.q = 2'h3;
               end
               default: begin
                  ctl_next.scl_oe = 1'b1;
                  ctl_next.q      = 2'h0;
                  if (ctl_reg.bit_cnt != 4'h0) begin
                     ctl_next.bit_cnt = ctl_reg.bit_cnt - 4'h1;
                  end else begin
                     ctl_next.bit_cnt = I2C_SLOT_LAST;
                     if (rx) begin
                        ctl_next.rd_data  = ctl_reg.sh;
                        ctl_next.rd_valid = 1'b1;
                        ctl_next.byte_cnt = ctl_reg.byte_cnt + 8'h01;
                        if (last_rd) ctl_next.st = ST_I2C_STOP;
                     end else if (ctl_reg.nak) begin
                        ctl_next.err = 1'b1;
                        ctl_next.st  = ST_I2C_STOP;
                     end else begin
                        case (ctl_reg.seg)
                           SEG_ADDR_W: begin
                              ctl_next.seg = SEG_IDX;
                              // index after the write address
                              ctl_next.sh  = {1'b0, ctl_reg.cmd.index[6:0]};
                           end
                           SEG_IDX: begin
                              if (ctl_reg.cmd.op == OP_WRITE) begin
                                 ctl_next.seg = SEG_WDATA;
                                 ctl_next.sh  = ctl_reg.cmd.wdata;
                              end else begin
                                 ctl_next.seg = SEG_ADDR_R;
                                 ctl_next.st  = ST_I2C_START;
                              end
                           end
                           SEG_ADDR_R: ctl_next.seg = SEG_RDATA;
                           default:    ctl_next.st  = ST_I2C_STOP;
                        endcase
                     end
                  end
               end
            endcase
         end
         ST_I2C_STOP: if (tick) begin
            case (ctl_reg.q)
               2'h0: begin
                  ctl_next.sda_oe = 1'b1;
                  ctl_next.q      = 2'h1;
               end
               2'h1: begin
                  ctl_next.scl_oe = 1'b0;
                  ctl_next.q      = 2'h2;
               end
               2'h2: if (scl_s) ctl_next.q = 2'h3;
               default: begin
                  ctl_next.sda_oe = 1'b0;
                  ctl_next.q      = 2'h0;
                  ctl_next.st     = ST_DONE;
               end
            endcase
         end
         ST_SPI_SEL: if (tick) begin
            ctl_next.mosi = ctl_reg.sh[7];
            ctl_next.st   = ST_SPI_BIT;
         end
         ST_SPI_BIT: if (tick) begin
            if (ctl_reg.q == 2'h0) begin
               ctl_next.sclk = 1'b1;
               ctl_next.sh   = {ctl_reg.sh[6:0], miso_s};
               ctl_next.q    = 2'h1;
            end else begin
               ctl_next.sclk = 1'b0;
               ctl_next.q    = 2'h0;
               if (ctl_reg.bit_cnt != 4'h0) begin
                  ctl_next.bit_cnt = ctl_reg.bit_cnt - 4'h1;
                  ctl_next.mosi    = ctl_reg.sh[7];
               end else begin
                  ctl_next.bit_cnt  = {1'b0, SPI_BIT_LAST};
                  ctl_next.byte_cnt = ctl_reg.byte_cnt + 8'h01;
                  ctl_next.sh = (ctl_reg.cmd.op == OP_WRITE)
                                ? ctl_reg.cmd.wdata : 8'h00;
                  ctl_next.mosi = (ctl_reg.cmd.op == OP_WRITE)
                                  && ctl_reg.cmd.wdata[7];
                  if (ctl_reg.byte_cnt != 8'h00
                      && ctl_reg.cmd.op != OP_WRITE) begin
                     ctl_next.rd_data  = ctl_reg.sh;
                     ctl_next.rd_valid = 1'b1;
                  end
                  if ({1'b0, ctl_reg.byte_cnt} + 9'h001 >= spi_bytes) begin
                     ctl_next.cs_n     = 1'b1;
                     ctl_next.st       = ST_SPI_GAP;
                     ctl_next.wait_cnt = 16'(CS_GAP_CYCLES - 1);
                  end else if (ctl_reg.byte_cnt == 8'h00
                               && ctl_reg.cmd.op == OP_CONV) begin
                     ctl_next.st       = ST_SPI_WAIT;
                     ctl_next.wait_cnt = 16'(CONV_CYCLES - 1);
                  end
               end
            end
         end
         ST_SPI_WAIT: begin
            // SCLK idles low for the whole conversion
            ctl_next.div = reload(1'b1);
            if (ctl_reg.wait_cnt == 16'h0000) begin
               ctl_next.st = ST_SPI_BIT;
            end else begin
               ctl_next.wait_cnt = ctl_reg.wait_cnt - 16'h0001;
            end
         end
         ST_SPI_GAP: begin
            if (ctl_reg.wait_cnt == 16'h0000) begin
               ctl_next.st = ST_DONE;
            end else begin
               ctl_next.wait_cnt = ctl_reg.wait_cnt - 16'h0001;
            end
         end
         default: begin
            ctl_next.done = 1'b1;
            ctl_next.st   = ST_IDLE;
         end
      endcase
      ctl_next.ready = (ctl_next.st == ST_IDLE) && !ctl_next.init_pend;
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         ctl_reg           <= '0;
         ctl_reg.st        <= ST_IDLE;
         ctl_reg.seg       <= SEG_ADDR_W;
         ctl_reg.init_pend <= 1'b1;
         ctl_reg.cs_n      <= 1'b1;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign cmd_ready_o     = ctl_reg.ready;
   assign rd_data_o       = ctl_reg.rd_data;
   assign rd_valid_o      = ctl_reg.rd_valid;
   assign done_o          = ctl_reg.done;
   assign nack_o          = ctl_reg.err;
   assign scl_o           = ctl_reg.nak & 1'b0;
   assign scl_oe_o        = ctl_reg.scl_oe;
   assign sda_o           = ctl_reg.nak & 1'b0;
   assign sda_oe_o        = ctl_reg.sda_oe;
   assign sclk_o          = ctl_reg.sclk;
   assign mosi_o          = ctl_reg.mosi;
   assign chip_select_n_o = ctl_reg.cs_n;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [7:0] gap_cnt_reg;
   logic [7:0] edge_cnt_reg;

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         gap_cnt_reg  <= GAP_CNT_RESET;
         edge_cnt_reg <= 8'h00;
      end else begin
         if (!ctl_reg.cs_n) gap_cnt_reg <= 8'h00;
         else if (gap_cnt_reg != GAP_CNT_RESET)
            gap_cnt_reg <= gap_cnt_reg + 8'h01;
         if (ctl_reg.cs_n) edge_cnt_reg <= 8'h00;
         else if (ctl_next.sclk && !ctl_reg.sclk)
            edge_cnt_reg <= edge_cnt_reg + 8'h01;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   sequence last_ack_s;
      ctl_reg.st == ST_I2C_BIT && rx && ctl_reg.bit_cnt == 4'h0
      && ctl_reg.q == 2'h3 && tick && last_rd;
   endsequence

   cs_gap_a: assert property ($fell(chip_select_n_o)
      |-> $past(gap_cnt_reg) >= 8'(CS_GAP_CYCLES))
      else $error("chip select high time too short");
   spi_wr_len_a: assert property ($rose(chip_select_n_o)
      && ctl_reg.cmd.op == OP_WRITE |-> edge_cnt_reg == 8'h10)
      else $error("spi write frame not 16 clocks");
   spi_rw_flag_a: assert property ($rose(sclk_o) &&
      edge_cnt_reg == 8'h01 |-> mosi_o == (ctl_reg.cmd.op != OP_WRITE))
      else $error("spi command flag wrong");
   spi_msb_first_a: assert property (ctl_reg.st == ST_SPI_BIT
      && ctl_reg.q == 2'h0 && ctl_reg.bit_cnt == 4'h7
      && ctl_reg.byte_cnt == 8'h00
      |-> mosi_o == (ctl_reg.cmd.op != OP_WRITE))
      else $error("spi command not msb first");
   conv_hold_a: assert property ($fell(ctl_reg.st == ST_SPI_WAIT)
      |-> $past(ctl_reg.wait_cnt) == 16'h0000 && !sclk_o && !chip_select_n_o)
      else $error("conversion wait cut short");
   idx_msb_a: assert property (ctl_reg.st == ST_I2C_BIT
      && ctl_reg.seg == SEG_IDX && ctl_reg.bit_cnt == 4'h8
      && ctl_reg.q != 2'h0 |-> sda_oe_o)
      else $error("i2c index msb not zero");
   rd_nack_a: assert property (ctl_reg.st == ST_I2C_BIT && rx
      && ctl_reg.bit_cnt == 4'h0 && ctl_reg.q == 2'h2
      |-> sda_oe_o == !last_rd)
      else $error("i2c read acknowledge wrong");
   stop_after_a: assert property (last_ack_s |=>
      ctl_reg.st == ST_I2C_STOP ##1 scl_oe_o)
      else $error("no stop after final nack");
   sr_read_a: assert property ($rose(ctl_reg.seg == SEG_ADDR_R)
      |-> ctl_reg.st == ST_I2C_START && ctl_reg.q == 2'h0)
      else $error("read address without repeated start");
   cs_idle_a: assert property (ctl_reg.st == ST_IDLE
      |-> chip_select_n_o)
      else $error("chip select low while idle");
endmodule // adsp_host
`default_nettype wire

// [verilog/adsp_pkg.sv]
/*
 * Shared constants and types of the host controller for the dual-protocol
 * accelerometer serial port. Assumes a 100 MHz controller clock.
 */
`default_nettype none
package adsp_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int CS_GAP_NS        = 130;
   localparam int CS_GAP_CYCLES    =
      (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_WAIT_US     = 200;
   localparam int CONV_WAIT_CYCLES =
      (CONV_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int I2C_QTR_CYCLES   = 25;
   localparam int SPI_HALF_CYCLES  = 8;

   // ------------------------------------------------------------
   // addresses and fixed values
   // ------------------------------------------------------------
   localparam logic [5:0] TARGET_ADDR_HI   = 6'h0C;
   localparam logic [7:0] CFG_B_INDEX      = 8'h0D;
   localparam logic [7:0] CFG_B_INIT       = 8'h42;
   localparam logic [3:0] I2C_SLOT_LAST    = 4'h8;
   localparam logic [2:0] SPI_BIT_LAST     = 3'h7;
   localparam logic [8:0] SPI_WR_BYTES     = 9'h002;
   localparam logic [7:0] GAP_CNT_RESET    = 8'hFF;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_READ  = 2'h1,
      OP_CONV  = 2'h2
   } adsp_op_type;

   typedef struct packed {
      logic        proto_spi;
      adsp_op_type op;
      logic [7:0]  index;
      logic [7:0]  wdata;
      logic [7:0]  count;
   } adsp_cmd_type;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_I2C_START = 9'h002,
      ST_I2C_BIT   = 9'h004,
      ST_I2C_STOP  = 9'h008,
      ST_SPI_SEL   = 9'h010,
      ST_SPI_BIT   = 9'h020,
      ST_SPI_WAIT  = 9'h040,
      ST_SPI_GAP   = 9'h080,
      ST_DONE      = 9'h100
   } adsp_state_type;

   typedef enum logic [4:0] {
      SEG_ADDR_W = 5'h01,
      SEG_IDX    = 5'h02,
      SEG_WDATA  = 5'h04,
      SEG_ADDR_R = 5'h08,
      SEG_RDATA  = 5'h10
   } adsp_seg_type;

   typedef struct packed {
      adsp_state_type st;
      adsp_seg_type   seg;
      adsp_cmd_type   cmd;
      logic [1:0]     q;
      logic [3:0]     bit_cnt;
      logic [7:0]     byte_cnt;
      logic [7:0]     sh;
      logic [7:0]     div;
      logic [15:0]    wait_cnt;
      logic           init_pend;
      logic           nak;
      logic           scl_oe;
      logic           sda_oe;
      logic           sclk;
      logic           mosi;
      logic           cs_n;
      logic [7:0]     rd_data;
      logic           rd_valid;
      logic           done;
      logic           err;
      logic           ready;
   } adsp_ctl_type;
endpackage
`default_nettype wire

// [tb/adsp_dev_model.sv]
/*
 * Behavioural model of the accelerometer serial port (I2C and SPI slave).
 * Assumes open-drain lines resolved by the bench; counts host faults in viol.
 */
`timescale 1ns/1ps
`default_nettype none
module adsp_dev_model #(
   parameter bit STRAP      = 1'b0,
   parameter int STRETCH_NS = 2000,
   parameter int CONV_NS    = 200000
) (
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic clock_hold_enable_i,
   output logic      scl_oe_o,
   output logic      sda_oe_o,
   input  wire logic sclk_i,
   input  wire logic mosi_i,
   input  wire logic chip_select_n_i,
   output logic      miso_o
);
   logic [7:0] regs [16];
   logic [7:0] sh, tx, ptr, ssh, sptr, stx, cmd;
   logic       act, rd;
   int         bc, ph, sbc, viol, nbyte, nstretch;
   realtime    t_cs, t_clk;
   function automatic logic [7:0] nxt(input logic [7:0] p);
      return p == 5 ? 8'h0E : p == 14 ? 8'h0D : p == 13 ? 8'h0C : 8'(p + 1);
   endfunction
   initial begin
      // control registers start cleared so the host's start-up write shows
      foreach (regs[i]) regs[i] = 8'h00;
      regs[0] = 8'hA5; regs[1] = 8'h30; regs[2] = 8'h5C;
      regs[3] = 8'h70; regs[4] = 8'hC3; regs[5] = 8'hE0; regs[14] = 8'h81;
      {scl_oe_o, sda_oe_o, miso_o, act, rd} = '0;
      {viol, nbyte, nstretch, sbc, bc, ph} = '0;
      t_cs = -1.0e6;
      t_clk = 0.0;
   end
   // ------------------------------------------------------------
   // i2c slave
   // ------------------------------------------------------------
   always @(negedge sda_i) if (scl_i === 1'b1) {act, bc, ph, rd} = {1'b1, 65'h0};
   always @(posedge sda_i) if (scl_i === 1'b1) act = 1'b0;
   always @(posedge scl_i) if (act) begin
      bc++;
      if (bc < 9) sh = {sh[6:0], sda_i};
      else if (rd && sda_i) act = 1'b0;
   end
   always @(negedge scl_i) if (act) begin
      if (bc == 8 && !rd) begin
         case (ph)
            0: begin
               sda_oe_o = (sh[7:1] == {6'h0C, STRAP});
               rd = sh[0];
               act = sda_oe_o;
            end
            1: begin ptr = sh; sda_oe_o = 1'b1; viol += sh[7]; end
            default: begin regs[ptr[3:0]] = sh; ptr++; sda_oe_o = 1'b1; end
         endcase
         ph++;
      end else if (bc == 8) sda_oe_o = 1'b0;
      else if (bc == 9) begin
         bc = 0;
         sda_oe_o = 1'b0;
         if (rd) begin
            if (ph == 1 && clock_hold_enable_i && ptr < 6) begin
               scl_oe_o = 1'b1;
               nstretch++;
               #(STRETCH_NS);
            end else if (ph != 1) ptr++;
            ph = 2;
            tx = regs[ptr[3:0]];
            nbyte++;
            sda_oe_o = ~tx[7];
            scl_oe_o = 1'b0;
         end
      end else if (rd && bc < 8) sda_oe_o = ~tx[3'(7 - bc)];
   end
   // ------------------------------------------------------------
   // spi slave
   // ------------------------------------------------------------
   always @(negedge chip_select_n_i) begin
      viol += ($realtime - t_cs < 130.0);
      sbc = 0;
   end
   always @(posedge chip_select_n_i) begin
      t_cs = $realtime;
      viol += (sbc >= 8 && !cmd[7] && sbc != 16);
      sbc = 0;
      miso_o = ~miso_o;
   end
   always @(posedge sclk_i) if (!chip_select_n_i) begin
      viol += (sbc == 8 && cmd[7] && cmd[6:0] < 6 && $realtime - t_clk < CONV_NS);
      ssh = {ssh[6:0], mosi_i};
      sbc++;
      if (sbc == 8) begin cmd = ssh; sptr = {1'b0, ssh[6:0]}; end
      else if (sbc % 8 == 0 && !cmd[7]) regs[cmd[3:0]] = ssh;
      else if (sbc % 8 == 0) sptr = nxt(sptr);
      if (sbc % 8 == 0) stx = regs[sptr[3:0]];
   end
   always @(negedge sclk_i) begin
      t_clk = $realtime;
      if (!chip_select_n_i) miso_o = stx[3'(7 - sbc % 8)];
   end
endmodule // adsp_dev_model
`default_nettype wire

// [tb/adsp_host_tb_top.sv]
/*
 * Self-checking bench of the serial host controller against the device model.
 * Assumes pull-ups on both open-drain lines.
 */
`timescale 1ns/1ps
`default_nettype none
module adsp_host_tb_top;
   import adsp_pkg::*;
   logic         mclk_i = 0, resetn_i = 0, addr_strap_i = 0, hold = 0;
   logic         cmd_valid_i = 0;
   adsp_cmd_type cmd_i = '0;
   logic [7:0]   rd_data_o, got [$];
   logic         cmd_ready_o, rd_valid_o, done_o, nack_o, scl_oe, sda_oe;
   logic         d_scl_oe, d_sda_oe, sclk, mosi, cs_n, miso;
   int           n_mismatch = 0, compares = 0;
   wire          scl_w = ~(scl_oe | d_scl_oe);
   wire          sda_w = ~(sda_oe | d_sda_oe);
   adsp_host #(.CONV_CYCLES(50), .QTR_CYCLES(4)) dut (.mclk_i(mclk_i),
      .resetn_i(resetn_i), .addr_strap_i(addr_strap_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o),
      .nack_o(nack_o), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .sclk_o(sclk),
      .mosi_o(mosi), .chip_select_n_o(cs_n), .miso_i(miso));
   adsp_dev_model #(.CONV_NS(500)) dev (.scl_i(scl_w), .sda_i(sda_w),
      .clock_hold_enable_i(hold), .scl_oe_o(d_scl_oe), .sda_oe_o(d_sda_oe),
      .sclk_i(sclk), .mosi_i(mosi), .chip_select_n_i(cs_n), .miso_o(miso));
   initial forever #5 mclk_i = ~mclk_i;
   task automatic check(input string what, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one request, waits for done and gathers the read bytes
   task automatic run(input logic spi, adsp_op_type op, logic [7:0] ix, wd, cnt);
      int n;
      n = 0;
      got.delete();
      do @(negedge mclk_i); while (cmd_ready_o !== 1'b1 && ++n < 20000);
      @(posedge mclk_i);
      cmd_i <= '{spi, op, ix, wd, cnt};
      cmd_valid_i <= 1'b1;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      do begin
         @(negedge mclk_i);
         if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
      end while (done_o !== 1'b1 && ++n < 40000);
      if (n >= 40000) begin n_mismatch++; results(); end
   endtask
   task automatic expect_bytes(input string what, logic [7:0] e [$]);
      check({what, " count"}, 8'(got.size()), 8'(e.size()));
      foreach (e[i]) if (i < got.size()) check(what, got[i], e[i]);
   endtask
   task automatic t_spi_wr_rd;
      run(1, OP_READ, 8'h0D, 8'h00, 8'h01);
      expect_bytes("startup b", '{8'h42});
      run(1, OP_WRITE, 8'h0C, 8'h3C, 8'h00);
      check("spi wr", dev.regs[12], 8'h3C);
      run(1, OP_READ, 8'h0C, 8'h00, 8'h00);
      expect_bytes("spi rd", '{8'h3C});
   endtask
   task automatic t_i2c_wr_rd;
      run(0, OP_WRITE, 8'h8A, 8'h5A, 8'h00);
      check("i2c wr", dev.regs[10], 8'h5A);
      check("i2c ack", nack_o, 1'b0);
      run(0, OP_READ, 8'h0A, 8'h00, 8'h03);
      expect_bytes("i2c rd", '{8'h5A, 8'h00, 8'h3C});
      check("i2c bus idle", dev.act, 1'b0);
   endtask
   task automatic t_foreign_addr;
      @(posedge mclk_i);
      addr_strap_i <= 1'b1;
      run(0, OP_WRITE, 8'h09, 8'h77, 8'h00);
      check("nack", nack_o, 1'b1);
      check("no store", dev.regs[9], 8'h00);
      @(posedge mclk_i);
      addr_strap_i <= 1'b0;
      run(0, OP_READ, 8'h09, 8'h00, 8'h01);
      check("nack clr", nack_o, 1'b0);
      expect_bytes("foreign rd", '{8'h00});
   endtask
   task automatic t_i2c_conv;
      int s;
      s = dev.nstretch;
      hold <= 1'b1;
      run(0, OP_CONV, 8'h00, 8'h00, 8'h02);
      expect_bytes("conv hold", '{8'hA5, 8'h30});
      check("stretch on", 8'(dev.nstretch - s), 8'h01);
      hold <= 1'b0;
      run(0, OP_CONV, 8'h04, 8'h00, 8'h02);
      expect_bytes("conv free", '{8'hC3, 8'hE0});
      check("stretch off", 8'(dev.nstretch - s), 8'h01);
   endtask
   task automatic t_spi_conv;
      run(1, OP_CONV, 8'h00, 8'h00, 8'h09);
      expect_bytes("conv seq", '{8'hA5, 8'h30, 8'h5C, 8'h70, 8'hC3, 8'hE0,
                                 8'h81, 8'h42, 8'h3C});
      run(1, OP_CONV, 8'h02, 8'h00, 8'h02);
      expect_bytes("conv restart", '{8'h5C, 8'h70});
      check("host faults", 8'(dev.viol), 8'h00);
   endtask
   initial begin
      repeat (4) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_spi_wr_rd();
      t_i2c_wr_rd();
      t_foreign_addr();
      t_i2c_conv();
      t_spi_conv();
      results();
   end
   initial begin
      #300000;
      n_mismatch++;
      results();
   end
endmodule // adsp_host_tb_top
`default_nettype wire
